// [verification/nml_loader_properties.sv]
// Purpose: Port timing properties of the image loader.
// Assumes: One clock domain, synchronous reset.
// Notes:   Attached to the loader by the bind below.
`timescale 1ns/1ps
`default_nettype none
module nml_loader_properties
   import nml_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       d3_exit,
   input wire logic       nvm_req,
   input wire logic [8:0] nvm_addr,
   input wire logic       nvm_ack,
   input wire logic       load_busy,
   input wire logic       signature_valid,
   input wire logic       receive_address_slot0_valid
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence sizing_fetch;
      nvm_req && nvm_addr == WA_SIZING;
   endsequence
   req_hold_a: assert property (nvm_req && !nvm_ack ##1 nvm_req
      |-> $stable(nvm_addr)) else $error("address moved mid request");
   ack_drop_a: assert property (nvm_req && nvm_ack |=> !nvm_req)
      else $error("request held after acknowledge");
   sizing_first_a: assert property ($fell(reset) |=> sizing_fetch)
      else $error("load did not start with sizing word");
   d3_reload_a: assert property (d3_exit && !load_busy
      |-> ##[1:3] sizing_fetch) else $error("no reload after wake");
   req_bound_a: assert property ($rose(nvm_req) |-> ##[1:501] !nvm_req)
      else $error("request never ended");
   sig_idle_a: assert property (signature_valid ||
      receive_address_slot0_valid |-> !load_busy)
      else $error("valid flag raised while loading");
   valid_late_a: assert property ($rose(receive_address_slot0_valid)
      |-> $past(!load_busy) && $past(load_busy, 2))
      else $error("slot valid not one cycle after load end");
   valid_sig_a: assert property (receive_address_slot0_valid
      && !load_busy |-> signature_valid) else $error("valid without sig");
endmodule : nml_loader_properties
bind nml_loader nml_loader_properties nml_loader_properties_inst (
   .clk_sys(clk_sys), .reset(reset), .d3_exit(d3_exit),
   .nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
   .load_busy(load_busy), .signature_valid(signature_valid),
   .receive_address_slot0_valid(receive_address_slot0_valid));
`default_nettype wire

// [verification/nml_nvm_model.sv]
// Purpose: Storage partner answering word reads of the image.
// Assumes: Answers on clk_sys after a settable delay.
// Notes:   Read data toggles whenever it is not acknowledged.
`timescale 1ns/1ps
`default_nettype none
module nml_nvm_model
(
   input  wire logic        clk_sys,
   input  wire logic        nvm_req,
   input  wire logic [8:0]  nvm_addr,
   output logic             nvm_ack,
   output logic [15:0]      nvm_rdata
);
   logic [15:0] mem [0:511];
   int          lat = 0;
   int          cnt = 0;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      nvm_ack   = 1'b0;
      nvm_rdata = 16'h0000;
   end
   // Toggling data keeps a stale word from passing as a good one.
   always @(posedge clk_sys) begin
      nvm_ack   <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (nvm_req && !nvm_ack) begin
         cnt <= cnt + 1;
         if (cnt >= lat) begin
            nvm_ack   <= 1'b1;
            nvm_rdata <= mem[nvm_addr];
            cnt       <= 0;
         end
      end
   end
endmodule : nml_nvm_model
`default_nettype wire

// [verification/tb_nml_loader.sv]
// Purpose: Self-checking bench for the image loader.
// Assumes: Inputs change at the falling edge of clk_sys.
// Notes:   Each scenario loads an image and checks the results.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_nml_loader;
   import nml_pkg::*;
   logic clk_sys = 1'b0, reset, d3_exit, port_sel, mgmt_enable;
   logic nvm_req, nvm_ack, load_busy, sig_ok, slot_ok, cls, short;
   logic [15:0] image_bytes, nvm_rdata;
   logic [8:0]  nvm_addr;
   logic [47:0] slot;
   int          failures = 0;
   int          n_tests = 0;
   always #10 clk_sys = ~clk_sys;
   nml_loader nml_loader_inst (.clk_sys(clk_sys), .reset(reset),
      .d3_exit(d3_exit), .port_sel(port_sel), .mgmt_enable(mgmt_enable),
      .image_bytes(image_bytes), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
      .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .load_busy(load_busy),
      .signature_valid(sig_ok), .receive_address_slot0(slot),
      .receive_address_slot0_valid(slot_ok),
      .config_class_load_bit(cls), .image_size_short(short));
   nml_nvm_model nml_nvm_model_inst (.clk_sys(clk_sys), .nvm_req(nvm_req),
      .nvm_addr(nvm_addr), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));
   task automatic wrap_up;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic load(input logic [15:0] w12, w0, w1, w2, w13,
                       input logic d3);
      int n;
      n = 0;
      nml_nvm_model_inst.mem[WA_SIZING] = w12;
      nml_nvm_model_inst.mem[WA_ADDR0] = w0;
      nml_nvm_model_inst.mem[WA_ADDR1] = w1;
      nml_nvm_model_inst.mem[WA_ADDR2] = w2;
      nml_nvm_model_inst.mem[WA_CLASS] = w13;
      if (d3) d3_exit = 1'b1;
      else reset = 1'b1;
      @(negedge clk_sys);
      d3_exit = 1'b0;
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      while (load_busy !== 1'b0 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(load_busy, 1'b0)
      repeat (2) @(negedge clk_sys);
   endtask : load
   task automatic t_good;
      image_bytes = 16'h01FF;
      load(16'h4000, 16'h1234, 16'h5678, 16'h9ABC, 16'h0000, 1'b0);
      `CHK(slot, 48'h9ABC_5678_1234)
      `CHK(slot_ok, 1'b1)
      `CHK(sig_ok, 1'b1)
      `CHK(cls, 1'b0)
      `CHK(short, 1'b1)
   endtask : t_good
   task automatic t_second;
      port_sel = 1'b1;
      image_bytes = 16'h0100;
      nml_nvm_model_inst.lat = 3;
      load(16'h4000, 16'h1111, 16'h5678, 16'h9ABC, 16'h8000, 1'b1);
      `CHK(slot, 48'h9BBC_5678_1111)
      `CHK(slot_ok, 1'b1)
      `CHK(cls, 1'b1)
      `CHK(short, 1'b0)
      port_sel = 1'b0;
   endtask : t_second
   task automatic t_badsig;
      load(16'h8000, 16'h1234, 16'h5678, 16'h9ABC, 16'h0000, 1'b0);
      `CHK(sig_ok, 1'b0)
      `CHK(slot_ok, 1'b0)
      `CHK(slot, SLOT_RESET)
      `CHK(cls, CLASS_RESET)
   endtask : t_badsig
   task automatic t_unused;
      mgmt_enable = 1'b0;
      image_bytes = 16'h0010;
      load(16'h4000, 16'h1234, UNUSED_WORD, 16'h9ABC, UNUSED_WORD, 1'b0);
      `CHK(slot_ok, 1'b0)
      `CHK(slot[31:16], 16'h0000)
      `CHK(cls, 1'b1)
      `CHK(short, 1'b0)
   endtask : t_unused
   // A silent storage part must time out into an unused sizing word.
   task automatic t_stuck;
      nml_nvm_model_inst.lat = 1000;
      load(16'h4000, 16'h1234, 16'h5678, 16'h9ABC, 16'h0000, 1'b0);
      `CHK(sig_ok, 1'b0)
      `CHK(slot_ok, 1'b0)
      `CHK(cls, CLASS_RESET)
   endtask : t_stuck
   initial begin
      reset = 1'b1;
      d3_exit = 1'b0;
      port_sel = 1'b0;
      mgmt_enable = 1'b1;
      image_bytes = 16'h01FF;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      // The first scenario then cuts a running fetch with a second reset.
      @(negedge clk_sys);
      t_good();
      t_second();
      t_badsig();
      t_unused();
      t_stuck();
      wrap_up();
   end
   // Loads take well under a thousand cycles; this catches a hang.
   initial begin
      #1_000_000;
      failures++;
      wrap_up();
   end
endmodule : tb_nml_loader
`default_nettype wire

// [verilog/nml_fetch_if.sv]
// Purpose: Carries one word request from the sequencer to the fetcher.
// Assumes: Both ends run on clk_sys.
// Notes:   start and done are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface nml_fetch_if;
   logic        start;
   logic [8:0]  addr;
   logic        done;
   logic [15:0] data;
   logic        unused;
   modport ctrl  (output start, output addr,
                  input done, input data, input unused);
   modport fetch (input start, input addr,
                  output done, output data, output unused);
endinterface : nml_fetch_if
`default_nettype wire

// [verilog/nml_loader.sv]
// Purpose: Loads the station address and class-load bit after reset.
// Assumes: Storage port, power events and straps are on clk_sys.
// Notes:   A wake from D3 during a load is absorbed by that load.
// Contract
// RULE1 - Apply words only with a valid signature.
// RULE2 - Load address words 0-2 into slot 0.
// RULE3 - Second port inverts bit 8 of word 2.
// RULE4 - All-ones word is treated as unused.
// RULE5 - Image must be 256 or 512 bytes.
// RULE6 - Each port and image gets unique address.
// RULE7 - Slot valid only after loading completes.
`timescale 1ns/1ps
`default_nettype none
module nml_loader
   import nml_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        d3_exit,
   input  wire logic        port_sel,
   input  wire logic        mgmt_enable,
   input  wire logic [15:0] image_bytes,
   output logic             nvm_req,
   output logic [8:0]       nvm_addr,
   input  wire logic        nvm_ack,
   input  wire logic [15:0] nvm_rdata,
   output logic             load_busy,
   output logic             signature_valid,
   output logic [47:0]      receive_address_slot0,
   output logic             receive_address_slot0_valid,
   output logic             config_class_load_bit,
   output logic             image_size_short
);
   typedef enum logic [2:0] {
      ST_SIG, ST_W0, ST_W1, ST_W2, ST_CLASS, ST_DONE
   } nml_state_t;

   nml_state_t  state_q;
   nml_state_t  state_d;
   logic        pend_q;
   logic        sig_q;
   logic [47:0] slot_q;
   logic        addr_ok_q;
   logic        valid_q;
   logic        class_q;
   logic        short_q;
   logic        busy_q;

   nml_fetch_if fif ();

   function automatic logic [8:0] word_of(input nml_state_t s);
      unique case (s)
         ST_SIG:   word_of = WA_SIZING;
         ST_W0:    word_of = WA_ADDR0;
         ST_W1:    word_of = WA_ADDR1;
         ST_W2:    word_of = WA_ADDR2;
         ST_CLASS: word_of = WA_CLASS;
         ST_DONE:  word_of = WA_SIZING;
      endcase
   endfunction : word_of

   ////////////////////////////////////////////////////////////////////
   nml_word_fetch u_fetch (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .fif       (fif.fetch),
      .nvm_req   (nvm_req),
      .nvm_addr  (nvm_addr),
      .nvm_ack   (nvm_ack),
      .nvm_rdata (nvm_rdata)
   );

   assign fif.start = busy_q && !pend_q;
   assign fif.addr  = word_of(state_q);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pend_q <= 1'b0;
      end else if (fif.start) begin
         pend_q <= 1'b1;
      end else if (fif.done) begin
         pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer: one word per state up to ST_CLASS, each advance on the fetch answer; ST_DONE restarts on d3_exit.
   always_comb begin
      state_d = state_q;
      if (state_q == ST_DONE) begin
         if (d3_exit) begin
            state_d = ST_SIG; // RULE2
         end
      end else if (fif.done) begin
         unique case (state_q)
            ST_SIG: begin
               if (!fif.unused &&
                   fif.data[SIG_MSB:SIG_LSB] == SIG_GOOD) begin
                  state_d = ST_W0; // RULE1
               end else begin
                  state_d = ST_DONE; // RULE1
               end
            end
            ST_W0:    state_d = ST_W1;
            ST_W1:    state_d = ST_W2;
            ST_W2:    state_d = ST_CLASS;
            ST_CLASS: state_d = ST_DONE;
            ST_DONE:  state_d = ST_DONE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= ST_SIG; // RULE2
         busy_q  <= 1'b1;
      end else begin
         state_q <= state_d;
         busy_q  <= (state_d != ST_DONE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sig_q <= 1'b0;
      end else if (fif.done && state_q == ST_SIG) begin
         sig_q <= !fif.unused &&
                  fif.data[SIG_MSB:SIG_LSB] == SIG_GOOD; // RULE1
      end
   end

   // Unused address words leave the slot word at its reset value.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         slot_q    <= SLOT_RESET;
         addr_ok_q <= 1'b0;
      end else if (fif.done) begin
         unique case (state_q)
            ST_SIG: begin
               slot_q    <= SLOT_RESET;
               addr_ok_q <= 1'b1;
            end
            ST_W0: begin
               if (fif.unused) begin
                  addr_ok_q <= 1'b0; // RULE4
               end else begin
                  slot_q[15:0] <= fif.data; // RULE2
               end
            end
            ST_W1: begin
               if (fif.unused) begin
                  addr_ok_q <= 1'b0; // RULE4
               end else begin
                  slot_q[31:16] <= fif.data; // RULE2
               end
            end
            ST_W2: begin
               if (fif.unused) begin
                  addr_ok_q <= 1'b0; // RULE4
               end else begin
                  slot_q[47:32] <= fif.data ^
                     (16'(port_sel) << FLIP_BIT); // RULE3
               end
            end
            ST_CLASS: begin
            end
            ST_DONE: begin
            end
         endcase
      end
   end

   // The slot reads valid only once every loaded word is in place.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         valid_q <= 1'b0;
      end else if (busy_q || state_d != ST_DONE) begin
         // A reload drops the slot flag on its first edge, not one later.
         valid_q <= 1'b0; // RULE7
      end else begin
         valid_q <= sig_q && addr_ok_q; // RULE7
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         class_q <= CLASS_RESET;
      end else if (fif.done && state_q == ST_CLASS && !fif.unused) begin
         class_q <= fif.data[CLASS_BIT]; // RULE4
      end
   end

   // Only a hint: the device keeps working with a short image.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         short_q <= 1'b0;
      end else if (busy_q) begin
         short_q <= 1'b0; // RULE7
      end else begin
         short_q <= sig_q && mgmt_enable &&
            (image_bytes < (class_q ? MIN_BYTES_CL
                                    : MIN_BYTES_NOCL)); // RULE5
      end
   end

   assign load_busy                   = busy_q;
   assign signature_valid             = sig_q && !busy_q;
   assign receive_address_slot0       = slot_q;
   assign receive_address_slot0_valid = valid_q;
   assign config_class_load_bit       = class_q;
   assign image_size_short            = short_q;
endmodule : nml_loader
`default_nettype wire

// [verilog/nml_pkg.sv]
// Purpose: Shared constants for the configuration image loader.
// Assumes: 16-bit image words addressed by word index.
// Notes:   Clock is clk_sys at 50 MHz.
`default_nettype none
package nml_pkg;
   localparam int          WORD_W         = 16;
   localparam int          ADDR_W         = 9;
   localparam int          CLK_HZ         = 50_000_000;
   localparam logic [8:0]  WA_ADDR0       = 9'h000;
   localparam logic [8:0]  WA_ADDR1       = 9'h001;
   localparam logic [8:0]  WA_ADDR2       = 9'h002;
   localparam logic [8:0]  WA_SIZING      = 9'h012;
   localparam logic [8:0]  WA_CLASS       = 9'h013;
   localparam int          SIG_MSB        = 15;
   localparam int          SIG_LSB        = 14;
   localparam logic [1:0]  SIG_GOOD       = 2'h1;
   localparam int          CLASS_BIT      = 15;
   localparam int          FLIP_BIT       = 8;
   localparam logic [15:0] UNUSED_WORD    = 16'hFFFF;
   localparam logic [15:0] MIN_BYTES_CL   = 16'h0100;
   localparam logic [15:0] MIN_BYTES_NOCL = 16'h0200;
   localparam logic [47:0] SLOT_RESET     = 48'h0;
   localparam logic        CLASS_RESET    = 1'b1;
   localparam int          FETCH_TMO_NS   = 10000;
   localparam int          FETCH_TMO_CYC  =
      (FETCH_TMO_NS / (1_000_000_000 / CLK_HZ) < 1) ? 1 :
      FETCH_TMO_NS / (1_000_000_000 / CLK_HZ);
endpackage : nml_pkg
`default_nettype wire

// [verilog/nml_word_fetch.sv]
// Purpose: Reads one image word over the request and acknowledge port.
// Assumes: The storage controller answers on clk_sys.
// Notes:   A missing answer is turned into an unused word.
`timescale 1ns/1ps
`default_nettype none
module nml_word_fetch
   import nml_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    reset,
   nml_fetch_if.fetch   fif,
   output logic         nvm_req,
   output logic [8:0]   nvm_addr,
   input  wire logic    nvm_ack,
   input  wire logic [15:0] nvm_rdata
);
   logic [15:0] tmo_q;
   logic [15:0] data_q;
   logic        done_q;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nvm_req  <= 1'b0;
         nvm_addr <= 9'h000;
         tmo_q    <= 16'h0000;
      end else if (fif.start) begin
         nvm_req  <= 1'b1;
         nvm_addr <= fif.addr;
         tmo_q    <= 16'h0000;
      end else if (nvm_req) begin
         if (nvm_ack || tmo_q == 16'(FETCH_TMO_CYC - 1)) begin
            nvm_req <= 1'b0;
         end
         tmo_q <= tmo_q + 16'h0001;
      end
   end

   // A stuck storage part must not hang the load forever.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_q <= UNUSED_WORD;
         done_q <= 1'b0;
      end else begin
         done_q <= nvm_req && !fif.start &&
                   (nvm_ack || tmo_q == 16'(FETCH_TMO_CYC - 1));
         if (nvm_req && nvm_ack) begin
            data_q <= nvm_rdata;
         end else if (nvm_req) begin
            data_q <= UNUSED_WORD;
         end
      end
   end

   assign fif.done   = done_q;
   assign fif.data   = data_q;
   assign fif.unused = (data_q == UNUSED_WORD); // RULE4
endmodule : nml_word_fetch
`default_nettype wire
